//--- design/rpm_top.sv
// Eight-input reference period monitor with an APB register slave.
// Assumes APB signals synchronous to pclk; reference inputs asynchronous.
`timescale 1ns/1ps
module rpm_top (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [rpm_pkg::NUM_CH-1:0]    ref_in,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic      [rpm_pkg::NUM_CH-1:0]    ref_fast,
   output logic      [rpm_pkg::NUM_CH-1:0]    ref_slow
);
   localparam int NCH = rpm_pkg::NUM_CH;

   logic                          run_ff;
   logic [rpm_pkg::DIV_W-1:0]     div_ff;
   logic                          tick_ff;
   logic [rpm_pkg::SYS_W-1:0]     core_tick_length_fs;
   logic [rpm_pkg::NOM_W-1:0]     expected_input_period_fs [NCH];
   logic [rpm_pkg::TOL_W-1:0]     deviation_inverse_count [NCH];
   logic [NCH-1:0]                ch_fast;
   logic [NCH-1:0]                ch_slow;
   logic [NCH-1:0]                ch_good;
   logic [NCH-1:0]                ch_valid;
   logic [rpm_pkg::OBS_W-1:0]     ch_obs [NCH];
   logic                          access;
   logic                          commit;
   logic                          in_ch;
   logic [11:0]                   ch_rel;
   logic [2:0]                    ch_idx;
   logic [3:0]                    ch_reg;
   logic [31:0]                   nxt_rdata;
   logic                          nxt_err;

   // sample tick every 32 system clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= div_ff + 5'h01;
         tick_ff <= (div_ff == rpm_pkg::DIV_LAST);
      end
   end

   // Access phase answered one cycle after it opens
   assign access = psel & penable & ~pready;
   assign commit = psel & penable & pready;

   // Channel window decode
   assign ch_rel = paddr - rpm_pkg::CH_BASE;
   assign in_ch  = (paddr >= rpm_pkg::CH_BASE) &&
                   (ch_rel < rpm_pkg::CH_SPAN * 12'(NCH)) && (paddr[1:0] == 2'h0);
   assign ch_idx = ch_rel[6:4];
   assign ch_reg = ch_rel[3:0];

   // Read data and error decode
   always_comb begin
      nxt_rdata = 32'h00000000;
      nxt_err   = 1'b0;
      if (paddr == rpm_pkg::CTRL_OFF) begin
         nxt_rdata = {31'h00000000, run_ff};
      end else if (paddr == rpm_pkg::SYS_OFF) begin
         nxt_rdata = {11'h000, core_tick_length_fs};
      end else if (in_ch) begin
         unique case (ch_reg)
            rpm_pkg::NOM_LO_OFF:
               nxt_rdata = expected_input_period_fs[ch_idx][31:0];
            rpm_pkg::NOM_HI_OFF:
               nxt_rdata = {14'h0000, expected_input_period_fs[ch_idx][49:32]};
            rpm_pkg::TOL_OFF:
               nxt_rdata = {12'h000, deviation_inverse_count[ch_idx]};
            rpm_pkg::STAT_OFF: begin
               nxt_rdata[rpm_pkg::ST_FAST]  = ch_fast[ch_idx];
               nxt_rdata[rpm_pkg::ST_SLOW]  = ch_slow[ch_idx];
               nxt_rdata[rpm_pkg::ST_GOOD]  = ch_good[ch_idx];
               nxt_rdata[rpm_pkg::ST_VALID] = ch_valid[ch_idx];
               nxt_rdata[31:rpm_pkg::ST_OBS_LSB] = ch_obs[ch_idx];
            end
            default: nxt_err = 1'b1;
         endcase
      end else begin
         nxt_err = 1'b1;
      end
   end

   // APB answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (access) begin
         pready  <= 1'b1;
         pslverr <= nxt_err;
         prdata  <= pwrite ? 32'h00000000 : nxt_rdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

   // control word and core tick length, shared by all monitors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff              <= 1'b0;
         core_tick_length_fs <= rpm_pkg::SYS_RST;
      end else if (commit && pwrite) begin
         if (paddr == rpm_pkg::CTRL_OFF) begin
            run_ff <= pwdata[0];
         end
         if (paddr == rpm_pkg::SYS_OFF) begin
            core_tick_length_fs <= pwdata[rpm_pkg::SYS_W-1:0];
         end
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            expected_input_period_fs[g] <= rpm_pkg::NOM_RST;
            deviation_inverse_count[g]  <= rpm_pkg::TOL_RST;
         end else if (commit && pwrite && in_ch && ch_idx == 3'(g)) begin
            if (ch_reg == rpm_pkg::NOM_LO_OFF) begin
               expected_input_period_fs[g][31:0] <= pwdata;
            end
            if (ch_reg == rpm_pkg::NOM_HI_OFF) begin
               expected_input_period_fs[g][49:32] <= pwdata[17:0];
            end
            if (ch_reg == rpm_pkg::TOL_OFF) begin
               deviation_inverse_count[g] <= pwdata[rpm_pkg::TOL_W-1:0];
            end
         end
      end

      rpm_chan u_chan (
         .pclk                     (pclk),
         .presetn                  (presetn),
         .run                      (run_ff),
         .tick                     (tick_ff),
         .ref_in                   (ref_in[g]),
         .core_tick_length_fs      (core_tick_length_fs),
         .expected_input_period_fs (expected_input_period_fs[g]),
         .deviation_inverse_count  (deviation_inverse_count[g]),
         .fast_ff                  (ch_fast[g]),
         .slow_ff                  (ch_slow[g]),
         .good_ff                  (ch_good[g]),
         .valid_ff                 (ch_valid[g]),
         .obs_n_ff                 (ch_obs[g])
      );
   end

   // Fault pins mirror the status flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_fast <= '0;
         ref_slow <= '0;
      end else begin
         ref_fast <= ch_fast;
         ref_slow <= ch_slow;
      end
   end
endmodule

//--- design/rpm_pkg.sv
// Constants shared by the reference period monitor top and its channel.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
package rpm_pkg;
   localparam int          NUM_CH       = 8;
   localparam int          SYS_W        = 21;
   localparam int          NOM_W        = 50;
   localparam int          TOL_W        = 20;
   localparam int          K_W          = 6;
   localparam int          ACC_W        = 80;
   localparam int          OBS_W        = 16;
   localparam int          DIV_W        = 5;
   localparam int          TICK_SHIFT   = 5;
   localparam logic [DIV_W-1:0] DIV_LAST = 5'h1F;
   localparam logic [K_W-1:0]   K_MAX    = 6'h3F;
   localparam logic [OBS_W-1:0] BASE_WIN = 16'h0003;
   localparam logic [OBS_W-1:0] MIN_OBS  = 16'h0007;
   localparam logic [OBS_W-1:0] OBS_MAX  = 16'hFFFF;
   // Register byte addresses
   localparam logic [11:0] CTRL_OFF     = 12'h000;
   localparam logic [11:0] SYS_OFF      = 12'h004;
   localparam logic [11:0] CH_BASE      = 12'h020;
   localparam logic [11:0] CH_SPAN      = 12'h010;
   localparam logic [3:0]  NOM_LO_OFF   = 4'h0;
   localparam logic [3:0]  NOM_HI_OFF   = 4'h4;
   localparam logic [3:0]  TOL_OFF      = 4'h8;
   localparam logic [3:0]  STAT_OFF     = 4'hC;
   // Status bit positions
   localparam int          ST_FAST      = 0;
   localparam int          ST_SLOW      = 1;
   localparam int          ST_GOOD      = 2;
   localparam int          ST_VALID     = 3;
   localparam int          ST_OBS_LSB   = 16;
   // Reset values
   localparam logic [SYS_W-1:0] SYS_RST = 21'h000000;
   localparam logic [NOM_W-1:0] NOM_RST = 50'h0;
   localparam logic [TOL_W-1:0] TOL_RST = 20'h00001;
endpackage

//--- design/rpm_chan.sv
// One reference monitor: edge counter, residual accumulator, window compare.
// Assumes tick is a one-cycle pulse every 32 pclk and ref_in is asynchronous.
`timescale 1ns/1ps
module rpm_chan (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         run,
   input  wire logic                         tick,
   input  wire logic                         ref_in,
   input  wire logic [rpm_pkg::SYS_W-1:0]    core_tick_length_fs,
   input  wire logic [rpm_pkg::NOM_W-1:0]    expected_input_period_fs,
   input  wire logic [rpm_pkg::TOL_W-1:0]    deviation_inverse_count,
   output logic                              fast_ff,
   output logic                              slow_ff,
   output logic                              good_ff,
   output logic                              valid_ff,
   output logic      [rpm_pkg::OBS_W-1:0]    obs_n_ff
);
   logic                         ref_meta_ff;
   logic                         ref_sync_ff;
   logic                         ref_prev_ff;
   logic [rpm_pkg::K_W-1:0]      edge_cnt_ff;
   logic [rpm_pkg::TOL_W-1:0]    tol_cnt_ff;
   logic signed [rpm_pkg::ACC_W-1:0] running_residual;
   logic                         fault_fast_ff;
   logic                         fault_slow_ff;
   logic                         edge_seen;
   logic [rpm_pkg::K_W-1:0]      k_now;
   logic [rpm_pkg::K_W+rpm_pkg::NOM_W-1:0] prod;
   logic signed [rpm_pkg::ACC_W-1:0] nxt_residual;
   logic signed [rpm_pkg::ACC_W-1:0] decision_window;
   logic [rpm_pkg::OBS_W+rpm_pkg::SYS_W:0] win_units;
   logic                         fast_hit;
   logic                         slow_hit;
   logic                         tol_wrap;
   logic                         obs_end;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_meta_ff <= 1'b0;
         ref_sync_ff <= 1'b0;
         ref_prev_ff <= 1'b0;
      end else begin
         ref_meta_ff <= ref_in;
         ref_sync_ff <= ref_meta_ff;
         ref_prev_ff <= ref_sync_ff;
      end
   end
   assign edge_seen = ref_sync_ff & ~ref_prev_ff;

   assign k_now = (edge_seen && edge_cnt_ff != rpm_pkg::K_MAX) ?
                  edge_cnt_ff + 6'h01 : edge_cnt_ff;

   // step is count times expected less sample period
   assign prod = k_now * expected_input_period_fs;
   assign nxt_residual = running_residual
      + $signed({{(rpm_pkg::ACC_W-rpm_pkg::K_W-rpm_pkg::NOM_W){1'b0}}, prod})
      - $signed({{(rpm_pkg::ACC_W-rpm_pkg::SYS_W-rpm_pkg::TICK_SHIFT){1'b0}},
                 core_tick_length_fs, 5'h00});

   // window is (3 + N) sample-period units
   // Product gets its own full-width net so no bits fall off inside the concatenation
   assign win_units = ({1'b0, obs_n_ff} + {1'b0, rpm_pkg::BASE_WIN}) * core_tick_length_fs;
   assign decision_window = $signed({{(rpm_pkg::ACC_W-rpm_pkg::OBS_W-rpm_pkg::SYS_W
      -rpm_pkg::TICK_SHIFT-1){1'b0}}, win_units, 5'h00});

   assign fast_hit = tick && k_now != '0 && nxt_residual > decision_window;
   assign slow_hit = tick && k_now != '0 && nxt_residual < -decision_window;

   // timer period ends after tol sample ticks
   assign tol_wrap = tick && ({1'b0, tol_cnt_ff} + 21'h000001 >=
                     {1'b0, deviation_inverse_count});
   // end needs seven periods and a reference edge
   assign obs_end = tick && k_now != '0 && obs_n_ff >= rpm_pkg::MIN_OBS;

   // sample tick clears the edge counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_ff <= '0;
      end else if (!run || tick) begin
         edge_cnt_ff <= '0;
      end else begin
         edge_cnt_ff <= k_now;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_residual <= '0;
      end else if (!run || obs_end) begin
         running_residual <= '0;
      end else if (tick) begin
         running_residual <= nxt_residual;
      end
   end

   // tolerance timer on the sample tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tol_cnt_ff <= '0;
         obs_n_ff   <= '0;
      end else if (!run || obs_end) begin
         tol_cnt_ff <= '0;
         obs_n_ff   <= '0;
      end else if (tol_wrap) begin
         tol_cnt_ff <= '0;
         if (obs_n_ff != rpm_pkg::OBS_MAX) begin
            obs_n_ff <= obs_n_ff + 16'h0001;
         end
      end else if (tick) begin
         tol_cnt_ff <= tol_cnt_ff + 20'h00001;
      end
   end

   // faults flag at once, verdict latched at end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_fast_ff <= 1'b0;
         fault_slow_ff <= 1'b0;
         fast_ff       <= 1'b0;
         slow_ff       <= 1'b0;
         good_ff       <= 1'b0;
         valid_ff      <= 1'b0;
      end else if (!run) begin
         fault_fast_ff <= 1'b0;
         fault_slow_ff <= 1'b0;
         fast_ff       <= 1'b0;
         slow_ff       <= 1'b0;
         good_ff       <= 1'b0;
         valid_ff      <= 1'b0;
      end else if (obs_end) begin
         fault_fast_ff <= 1'b0;
         fault_slow_ff <= 1'b0;
         fast_ff       <= fault_fast_ff | fast_hit;
         slow_ff       <= fault_slow_ff | slow_hit;
         good_ff       <= ~(fault_fast_ff | fast_hit | fault_slow_ff | slow_hit);
         valid_ff      <= 1'b1;
      end else begin
         fault_fast_ff <= fault_fast_ff | fast_hit;
         fault_slow_ff <= fault_slow_ff | slow_hit;
         if (fast_hit) begin
            fast_ff <= 1'b1;
            good_ff <= 1'b0;
         end
         if (slow_hit) begin
            slow_ff <= 1'b1;
            good_ff <= 1'b0;
         end
      end
   end
endmodule

//--- test/rpm_top_monitor.sv
// Checker for the monitor top: APB answers and flag timing at the pins.
// Assumes the sample tick runs free from reset release, one per 32 pclk.
`timescale 1ns/1ps
module rpm_top_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [11:0]                paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [rpm_pkg::NUM_CH-1:0] ref_in,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [rpm_pkg::NUM_CH-1:0] ref_fast,
   input wire logic [rpm_pkg::NUM_CH-1:0] ref_slow
);
   logic [4:0] phase_ff;
   logic [3:0] run_wr_ff;
   logic       bad_addr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Tick phase and history of run-control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff  <= 5'h00;
         run_wr_ff <= 4'h0;
      end else begin
         phase_ff  <= phase_ff + 5'h01;
         run_wr_ff <= {run_wr_ff[2:0], psel & penable & pready & pwrite & (paddr == 12'h000)};
      end
   end
   // Holes and misaligned places in the map
   assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > 12'h004 && paddr < 12'h020)
                     || (paddr > 12'h09F);
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("pready held past one cycle");
   property p_rdy_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_rdy_answer: assert property (p_rdy_answer)
      else $error("no answer one cycle into access");
   property p_rdy_cause;
      pready |-> $past(psel && penable);
   endproperty
   a_rdy_cause: assert property (p_rdy_cause)
      else $error("pready without access");
   property p_rd_idle;
      !pready |-> prdata == 32'h00000000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside answer");
   property p_err_rdy;
      pslverr |-> pready;
   endproperty
   a_err_rdy: assert property (p_err_rdy)
      else $error("error without pready");
   property p_err_map;
      pready |-> pslverr == bad_addr;
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("error flag does not match map");
   property p_flag_rise;
      ((ref_fast & ~$past(ref_fast)) != 0) || ((ref_slow & ~$past(ref_slow)) != 0)
         |-> phase_ff == 5'h02;
   endproperty
   a_flag_rise: assert property (p_flag_rise)
      else $error("flag rose off the tick phase");
   property p_flag_hold;
      phase_ff != 5'h02 && run_wr_ff == 4'h0 |-> $stable(ref_fast) && $stable(ref_slow);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag moved between ticks");
endmodule

bind rpm_top rpm_top_monitor rpm_top_monitor_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .ref_in(ref_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ref_fast(ref_fast), .ref_slow(ref_slow));

//--- test/rpm_ref_src.sv
// Eight free reference clock sources with programmable half periods.
// Assumes a zero half period means the source is absent and held low.
`timescale 1ns/1ps
module rpm_ref_src (
   input  wire logic [31:0]                half_ps [8],
   output logic      [rpm_pkg::NUM_CH-1:0] ref_out
);
   for (genvar c = 0; c < 8; c++) begin : g_src
      logic r;
      assign ref_out[c] = r;
      initial begin
         r = 1'b0;
         #(1.3 * c + 0.7);
         forever begin
            if (half_ps[c] == 32'h0) begin
               r = 1'b0;
               #1;
            end else begin
               #(half_ps[c] / 1000.0);
               r = ~r;
            end
         end
      end
   end
endmodule

//--- test/rpm_top_tb.sv
// Testbench for the monitor top: registers, decisions and run control.
// Assumes the source model on ref_in and the bound checker.
`timescale 1ns/1ps
module rpm_top_tb;
   localparam longint TCLK = 64'h0000000001E84800;
   logic                        pclk;
   logic                        presetn;
   logic                        psel;
   logic                        penable;
   logic                        pwrite;
   logic [11:0]                 paddr;
   logic [31:0]                 pwdata;
   wire  [rpm_pkg::NUM_CH-1:0]  ref_in;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   logic [rpm_pkg::NUM_CH-1:0]  ref_fast;
   logic [rpm_pkg::NUM_CH-1:0]  ref_slow;
   logic [31:0]                 half_ps [8];
   int                          per_ps  [8];
   int                          nom_ps  [8];
   int                          err_count;
   int                          compares;
   logic [31:0]                 seed;
   logic [31:0]                 q;
   logic [31:0]                 d;
   logic [63:0]                 nom;
   logic [1:0]                  f;
   logic                        e;
   rpm_top rpm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ref_in(ref_in), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_fast(ref_fast), .ref_slow(ref_slow));
   rpm_ref_src rpm_ref_src_i (.half_ps(half_ps), .ref_out(ref_in));
   // Clock
   always #2.5 pclk = ~pclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] cha(int c);
      return rpm_pkg::CH_BASE + rpm_pkg::CH_SPAN * 12'(c);
   endfunction
   // Ideal residual walk, result is slow and fast seen so far
   function automatic logic [1:0] expect_flags(int p, int n, int ticks);
      longint acc;
      longint k;
      longint thr;
      logic [1:0] r;
      acc = 0;
      r = 2'b00;
      for (int t = 1; t <= ticks && p != 0; t++) begin
         k = (t * TCLK) / (p * 200) - ((t - 1) * TCLK) / (p * 200);
         acc += k * n * 200 - TCLK;
         thr = (3 + (t - 1) / 64) * TCLK;
         if (k != 0 && acc > thr) r[0] = 1'b1;
         if (k != 0 && acc < -thr) r[1] = 1'b1;
      end
      return r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, x, g);
      end
   endtask
   // One APB transfer, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("register", x, q & m);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (30000) @(posedge pclk);
      err_count++;
      finish_test();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {err_count, compares} = '0;
      seed = 32'h00004131;
      half_ps = '{default: 32'h0};
      per_ps = '{20000, 18000, 22000, 0, 400000, 12000, 20000, 20000};
      nom_ps = '{20000, 20000, 20000, 20000, 400000, 20000, 20000, 20000};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, field widths, read-only status, map holes
      rdchk(12'h000, 32'hFFFFFFFF, 32'h0);
      for (int c = 0; c < 8; c++) begin
         rdchk(cha(c) + rpm_pkg::TOL_OFF, 32'hFFFFFFFF, 32'h00000001);
         d = rnd();
         apb(1'b1, cha(c) + rpm_pkg::NOM_HI_OFF, d);
         rdchk(cha(c) + rpm_pkg::NOM_HI_OFF, 32'hFFFFFFFF, d & 32'h0003FFFF);
         apb(1'b1, cha(c) + rpm_pkg::STAT_OFF, d);
         rdchk(cha(c) + rpm_pkg::STAT_OFF, 32'hFFFFFFFF, 32'h0);
      end
      d = rnd();
      apb(1'b1, rpm_pkg::SYS_OFF, d);
      rdchk(rpm_pkg::SYS_OFF, 32'hFFFFFFFF, d & 32'h001FFFFF);
      apb(1'b1, 12'h0A2, d);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      $display("test registers done");
      // Set up eight monitors, two of them at random periods
      d = rnd();
      per_ps[6] = 20000 + (d[0] ? 2 : -2) * int'(d[8:1] % 75);
      per_ps[7] = 20000 + (d[9] ? 1 : -1) * (1200 + 2 * int'(d[20:10] % 900));
      apb(1'b1, rpm_pkg::SYS_OFF, 32'h000F4240);
      for (int c = 0; c < 8; c++) begin
         nom = 64'(nom_ps[c]) * 200;
         half_ps[c] = per_ps[c] / 2;
         apb(1'b1, cha(c), nom[31:0]);
         apb(1'b1, cha(c) + rpm_pkg::NOM_HI_OFF, {14'h0, nom[49:32]});
         apb(1'b1, cha(c) + rpm_pkg::TOL_OFF, 32'h00000040);
      end
      apb(1'b1, 12'h000, 32'h00000001);
      // Early decisions, no verdict of good yet
      repeat (6400) @(posedge pclk);
      for (int c = 0; c < 6; c++) begin
         f = expect_flags(per_ps[c], nom_ps[c], 200);
         rdchk(cha(c) + rpm_pkg::STAT_OFF, 32'hF, {30'h0, f});
      end
      $display("test early decisions done");
      // Verdict after the full observation
      repeat (8640) @(posedge pclk);
      for (int c = 0; c < 8; c++) begin
         f = expect_flags(per_ps[c], nom_ps[c], 448);
         d = per_ps[c] != 0 ? {28'h0, 1'b1, ~|f, f} : 32'h0;
         rdchk(cha(c) + rpm_pkg::STAT_OFF, 32'hF, d);
         chk("pins", {30'h0, f}, {30'h0, ref_slow[c], ref_fast[c]});
      end
      $display("test verdicts done");
      // Stopping the monitors clears every flag
      apb(1'b1, 12'h000, 32'h0);
      repeat (4) @(posedge pclk);
      chk("flags off", 32'h0, {16'h0, ref_slow, ref_fast});
      rdchk(cha(1) + rpm_pkg::STAT_OFF, 32'hF, 32'h0);
      $display("test stop done");
      finish_test();
   end
endmodule
